// ===== hw/dli_defs.svh
`ifndef DLI_DEFS_SVH
`define DLI_DEFS_SVH

// ==========================================================================
// register indices (byte address = index * 4)
`define DLI_IDX_CTRL 6'd0
`define DLI_IDX_WAITCTL 6'd1
`define DLI_IDX_ERRSTAT 6'd2
`define DLI_IDX_IRQSTAT 6'd3
`define DLI_IDX_XFER 6'd4
`define DLI_IDX_RDATA 6'd5
`define DLI_IDX_LAST 6'd5

// ==========================================================================
// control register fields
`define DLI_CTRL_EN_BIT 0
`define DLI_WAITCTL_IRQEN_BIT 7
`define DLI_WAITCTL_LIMIT_MSB 3
`define DLI_WAITCTL_LIMIT_LSB 0

// ==========================================================================
// error status fields
`define DLI_ERR_SUM_BIT 7
`define DLI_ERR_ACK_BIT 6
`define DLI_ERR_CNCL_BIT 5
`define DLI_ERR_TIME_BIT 4
`define DLI_ERR_TGT_BIT 3
`define DLI_ERR_PAR_BIT 2

// ==========================================================================
// transfer request fields
`define DLI_XFER_READ_BIT 16
`define DLI_XFER_ADDR_MSB 15
`define DLI_XFER_ADDR_LSB 8
`define DLI_XFER_DATA_MSB 7
`define DLI_XFER_DATA_LSB 0

// ==========================================================================
// reset values and link encodings
`define DLI_RST_BYTE 8'h00
`define DLI_RST_LIMIT 4'h0
`define DLI_CMD_IDLE 8'h00
`define DLI_CMD_START 8'h80
`define DLI_CMD_READ 8'h40
`define DLI_ACK_WRITE 8'hff

`endif

// ===== hw/dli_pkg.sv
`include "dli_defs.svh"

package dli_pkg;
    typedef enum logic [4:0] {
        DLI_I_IDLE = 5'b00001,
        DLI_I_CMD = 5'b00010,
        DLI_I_ADDR = 5'b00100,
        DLI_I_WDAT = 5'b01000,
        DLI_I_WAIT = 5'b10000
    } dli_init_state_t;

    typedef enum logic [4:0] {
        DLI_T_IDLE = 5'b00001,
        DLI_T_ADDR = 5'b00010,
        DLI_T_DATA = 5'b00100,
        DLI_T_WAIT = 5'b01000,
        DLI_T_ACK = 5'b10000
    } dli_tgt_state_t;

    typedef logic [7:0] dli_byte_t;
endpackage

// ===== hw/dli_link_if.sv
`timescale 1ns/1ps

interface dli_link_if;
    logic linkClk;
    logic [7:0] cmdData;
    logic [7:0] rspData;
    logic [1:0] rspParity;
    logic rspAck;
    logic rspErr;
    logic targetIrqPin;

    modport initiator (
        output linkClk,
        output cmdData,
        input rspData,
        input rspParity,
        input rspAck,
        input rspErr,
        input targetIrqPin
    );

    modport target (
        input linkClk,
        input cmdData,
        output rspData,
        output rspParity,
        output rspAck,
        output rspErr,
        output targetIrqPin
    );
endinterface

// ===== hw/dli_target.sv
`timescale 1ns/1ps
`include "dli_defs.svh"

module dli_target
    import dli_pkg::*;
#(
    parameter int MEM_DEPTH = 256
) (
    // system
    input wire logic core_clk,
    input wire logic srst,
    // user side
    input wire logic irqReq,
    input wire logic [3:0] waitStates,
    input wire logic errInject,
    input wire logic parityInject,
    output logic wrStrobe,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData,
    // link
    dli_link_if.target link
);
    dli_tgt_state_t st, next_st;
    logic isRead, next_isRead;
    logic [7:0] addr, next_addr;
    logic [3:0] cnt, next_cnt;
    logic ack, next_ack;
    logic err, next_err;
    logic [7:0] data, next_data;
    logic [1:0] par, next_par;
    logic irqPin;
    logic next_wrStrobe;
    logic [7:0] mem [MEM_DEPTH];
    logic tick;
    logic [7:0] ackData;
    logic [7:0] ackAddr;

    assign tick = link.linkClk;
    assign ackAddr = (st == DLI_T_ADDR) ? link.cmdData : addr;
    assign ackData = isRead ? mem[ackAddr] : `DLI_ACK_WRITE;

    // ======================================================================
    // responder
    always_comb begin
        next_st = st;
        next_isRead = isRead;
        next_addr = addr;
        next_cnt = cnt;
        next_ack = ack;
        next_err = err;
        next_data = data;
        next_par = par;
        next_wrStrobe = 1'b0;
        if (tick) begin
            case (st)
                DLI_T_IDLE: begin
                    if (link.cmdData[7]) begin
                        next_isRead = link.cmdData[6];
                        next_st = DLI_T_ADDR;
                    end
                end
                DLI_T_ADDR: begin
                    next_addr = link.cmdData;
                    next_st = isRead ? DLI_T_WAIT : DLI_T_DATA;
                end
                DLI_T_DATA: begin
                    next_wrStrobe = 1'b1;
                    next_st = DLI_T_WAIT;
                end
                DLI_T_ACK: begin
                    next_ack = 1'b0;
                    next_err = 1'b0;
                    next_st = DLI_T_IDLE;
                end
                default: begin
                    if (cnt != 4'h0) begin
                        next_cnt = cnt - 4'h1;
                    end
                end
            endcase
            // last transfer cycle seen: ack at once or after the wait states
            if ((st == DLI_T_ADDR && isRead) || st == DLI_T_DATA) begin
                next_cnt = waitStates;
            end
            if (((st == DLI_T_ADDR && isRead) || st == DLI_T_DATA) && waitStates == 4'h0 ||
                (st == DLI_T_WAIT && cnt == 4'h1)) begin
                next_ack = 1'b1;
                next_err = errInject;
                next_data = ackData;
                next_par = {^ackData[7:4], ^ackData[3:0] ^ parityInject};
                next_st = DLI_T_ACK;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= DLI_T_IDLE;
            isRead <= 1'b0;
            addr <= `DLI_RST_BYTE;
            cnt <= 4'h0;
            ack <= 1'b0;
            err <= 1'b0;
            data <= `DLI_RST_BYTE;
            par <= 2'h0;
            irqPin <= 1'b0;
            wrStrobe <= 1'b0;
            wrAddr <= `DLI_RST_BYTE;
            wrData <= `DLI_RST_BYTE;
        end else begin
            st <= next_st;
            isRead <= next_isRead;
            addr <= next_addr;
            cnt <= next_cnt;
            ack <= next_ack;
            err <= next_err;
            data <= next_data;
            par <= next_par;
            irqPin <= irqReq;
            wrStrobe <= next_wrStrobe;
            if (next_wrStrobe) begin
                wrAddr <= addr;
                wrData <= link.cmdData;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (next_wrStrobe) begin
            mem[addr] <= link.cmdData;
        end
    end

    assign link.rspAck = ack;
    assign link.rspErr = err;
    assign link.rspData = data;
    assign link.rspParity = par;
    assign link.targetIrqPin = irqPin;
endmodule

// ===== hw/dli_initiator.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "dli_defs.svh"

// How it works
// - interrupt enable bit gates target interrupt to CPU
// - wait field sets allowed link wait cycles
// - exceeded wait limit sets timeout flag
// - zero limit expects ack right after transfer
// - target may insert up to limit waits
// - wait field locked after enable, normal mode
// - software writes zero to reserved control bits
// - any detailed error sets summary flag
// - error interrupt follows summary, no mask
// - write one clears summary, zero ignored
// - write ack not all ones sets fault
// - detailed flags read-only, cleared with summary
// - request during pending error sets cancel flag
// - target error in ack sets flag
// - read parity mismatch sets parity flag
// - received parity bits shown in status
// - status mirrors target interrupt pin live
// - target clears its own interrupt line
// - busy bit shows transaction in progress
// - software masks reserved status bits
// - pending error freezes buffers, sends idle
// - enabled link runs clock, idles low
module dli_initiator
    import dli_pkg::*;
(
    // system
    input wire logic core_clk,
    input wire logic srst,
    input wire logic specialMode,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu interrupts
    output logic linkErrIrq,
    output logic targetIrqOut,
    // link
    dli_link_if.initiator link
);
    dli_init_state_t st, next_st;
    logic enable, next_enable;
    logic irqEn, next_irqEn;
    logic [3:0] waitLimit, next_waitLimit;
    logic errSum, next_errSum;
    logic ackFault, next_ackFault;
    logic cancelF, next_cancelF;
    logic timeoutF, next_timeoutF;
    logic tgtErrF, next_tgtErrF;
    logic parity_error_flag, next_parity_error_flag;
    logic [1:0] parRx, next_parRx;
    logic phase, next_phase;
    logic [3:0] waitCnt, next_waitCnt;
    logic [7:0] cmdOut, next_cmdOut;
    logic pend, next_pend;
    logic bufRead, next_bufRead;
    logic [7:0] bufAddr, next_bufAddr;
    logic [7:0] bufData, next_bufData;
    logic [7:0] rdData, next_rdData;
    logic [31:0] next_prdata;
    logic [5:0] idx;
    logic mapped;
    logic wrAcc;
    logic busy;
    logic tick;
    logic writable;
    logic [1:0] expPar;

    assign idx = paddr[7:2];
    assign mapped = (paddr[1:0] == 2'b00) && (idx <= `DLI_IDX_LAST);
    assign wrAcc = psel && penable && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign busy = (st != DLI_I_IDLE) || pend;
    assign tick = enable && phase;
    assign writable = !enable || specialMode;
    assign expPar = {^link.rspData[7:4], ^link.rspData[3:0]};

    // ======================================================================
    // registers and link sequencing
    always_comb begin
        next_st = st;
        next_enable = enable;
        next_irqEn = irqEn;
        next_waitLimit = waitLimit;
        next_errSum = errSum;
        next_ackFault = ackFault;
        next_cancelF = cancelF;
        next_timeoutF = timeoutF;
        next_tgtErrF = tgtErrF;
        next_parity_error_flag = parity_error_flag;
        next_parRx = parRx;
        next_waitCnt = waitCnt;
        next_cmdOut = cmdOut;
        next_pend = pend;
        next_bufRead = bufRead;
        next_bufAddr = bufAddr;
        next_bufData = bufData;
        next_rdData = rdData;
        next_phase = enable ? !phase : 1'b0;

        // clear first so that a same-cycle set wins
        if (wrAcc && idx == `DLI_IDX_ERRSTAT && pwdata[`DLI_ERR_SUM_BIT]) begin
            next_errSum = 1'b0;
            next_ackFault = 1'b0;
            next_cancelF = 1'b0;
            next_timeoutF = 1'b0;
            next_tgtErrF = 1'b0;
            next_parity_error_flag = 1'b0;
        end
        if (wrAcc) begin
            case (idx)
                `DLI_IDX_CTRL: begin
                    if (writable) begin
                        next_enable = pwdata[`DLI_CTRL_EN_BIT];
                    end
                end
                `DLI_IDX_WAITCTL: begin
                    next_irqEn = pwdata[`DLI_WAITCTL_IRQEN_BIT];
                    if (writable) begin
                        next_waitLimit = pwdata[`DLI_WAITCTL_LIMIT_MSB:`DLI_WAITCTL_LIMIT_LSB];
                    end
                end
                `DLI_IDX_XFER: begin
                    if (enable && !busy) begin
                        if (errSum) begin
                            next_cancelF = 1'b1;
                        end else begin
                            next_pend = 1'b1;
                            next_bufRead = pwdata[`DLI_XFER_READ_BIT];
                            next_bufAddr = pwdata[`DLI_XFER_ADDR_MSB:`DLI_XFER_ADDR_LSB];
                            next_bufData = pwdata[`DLI_XFER_DATA_MSB:`DLI_XFER_DATA_LSB];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        if (tick) begin
            case (st)
                DLI_I_IDLE: begin
                    next_cmdOut = `DLI_CMD_IDLE;
                    if (pend && !errSum) begin
                        next_pend = 1'b0;
                        next_cmdOut = `DLI_CMD_START | (bufRead ? `DLI_CMD_READ : `DLI_CMD_IDLE);
                        next_st = DLI_I_CMD;
                    end else if (pend) begin
                        next_pend = 1'b0;
                        next_cancelF = 1'b1;
                    end
                end
                DLI_I_CMD: begin
                    next_cmdOut = bufAddr;
                    next_st = DLI_I_ADDR;
                end
                DLI_I_ADDR: begin
                    next_waitCnt = 4'h0;
                    next_cmdOut = bufRead ? `DLI_CMD_IDLE : bufData;
                    next_st = bufRead ? DLI_I_WAIT : DLI_I_WDAT;
                end
                DLI_I_WDAT: begin
                    next_waitCnt = 4'h0;
                    next_cmdOut = `DLI_CMD_IDLE;
                    next_st = DLI_I_WAIT;
                end
                default: begin
                    if (link.rspAck) begin
                        next_st = DLI_I_IDLE;
                        next_parRx = link.rspParity;
                        if (link.rspErr) begin
                            next_tgtErrF = 1'b1;
                        end
                        if (!bufRead && link.rspData != `DLI_ACK_WRITE) begin
                            next_ackFault = 1'b1;
                        end
                        if (bufRead) begin
                            next_rdData = link.rspData;
                            if (link.rspParity != expPar) begin
                                next_parity_error_flag = 1'b1;
                            end
                        end
                    end else if (waitCnt == waitLimit) begin
                        next_timeoutF = 1'b1;
                        next_st = DLI_I_IDLE;
                    end else begin
                        next_waitCnt = waitCnt + 4'h1;
                    end
                end
            endcase
        end
        if (!enable) begin
            next_cmdOut = `DLI_CMD_IDLE;
        end
        if (next_ackFault || next_cancelF || next_timeoutF || next_tgtErrF || next_parity_error_flag) begin
            next_errSum = 1'b1;
        end
    end

    // ======================================================================
    // read data, sampled in the setup phase
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (psel && !penable) begin
            case (idx)
                `DLI_IDX_CTRL: next_prdata = {31'h0000_0000, enable};
                `DLI_IDX_WAITCTL: next_prdata = {24'h00_0000, irqEn, 3'b000, waitLimit};
                `DLI_IDX_ERRSTAT: next_prdata = {24'h00_0000, errSum, ackFault, cancelF, timeoutF,
                                                 tgtErrF, parity_error_flag, parRx};
                `DLI_IDX_IRQSTAT: next_prdata = {24'h00_0000, link.targetIrqPin, busy, 6'h00};
                `DLI_IDX_XFER: next_prdata = {15'h0000, bufRead, bufAddr, bufData};
                `DLI_IDX_RDATA: next_prdata = {24'h00_0000, rdData};
                default: next_prdata = 32'h0000_0000;
            endcase
        end else begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= DLI_I_IDLE;
            enable <= 1'b0;
            irqEn <= 1'b0;
            waitLimit <= `DLI_RST_LIMIT;
            errSum <= 1'b0;
            ackFault <= 1'b0;
            cancelF <= 1'b0;
            timeoutF <= 1'b0;
            tgtErrF <= 1'b0;
            parity_error_flag <= 1'b0;
            parRx <= 2'h0;
            phase <= 1'b0;
            waitCnt <= 4'h0;
            cmdOut <= `DLI_CMD_IDLE;
            pend <= 1'b0;
            bufRead <= 1'b0;
            bufAddr <= `DLI_RST_BYTE;
            bufData <= `DLI_RST_BYTE;
            rdData <= `DLI_RST_BYTE;
            prdata <= 32'h0000_0000;
        end else begin
            st <= next_st;
            enable <= next_enable;
            irqEn <= next_irqEn;
            waitLimit <= next_waitLimit;
            errSum <= next_errSum;
            ackFault <= next_ackFault;
            cancelF <= next_cancelF;
            timeoutF <= next_timeoutF;
            tgtErrF <= next_tgtErrF;
            parity_error_flag <= next_parity_error_flag;
            parRx <= next_parRx;
            phase <= next_phase;
            waitCnt <= next_waitCnt;
            cmdOut <= next_cmdOut;
            pend <= next_pend;
            bufRead <= next_bufRead;
            bufAddr <= next_bufAddr;
            bufData <= next_bufData;
            rdData <= next_rdData;
            prdata <= next_prdata;
        end
    end

    assign linkErrIrq = errSum;
    assign targetIrqOut = irqEn && link.targetIrqPin;
    assign link.linkClk = phase;
    assign link.cmdData = cmdOut;
endmodule

// ===== tb/dli_assertions.sv
`timescale 1ns/1ps

// ==========================================
// link wire checks between the two ends
module dli_assertions (
    // system
    input wire logic core_clk,
    input wire logic srst,
    // link
    input wire logic linkClk,
    input wire logic [7:0] cmdData,
    input wire logic [7:0] rspData,
    input wire logic [1:0] rspParity,
    input wire logic rspAck,
    input wire logic rspErr,
    input wire logic targetIrqPin
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    chk_clk_high_once: assert property (linkClk |=> !linkClk)
        else $error("link clock high for more than one cycle");
    chk_clk_runs: assert property ((cmdData != 8'h00) && !linkClk |=> linkClk)
        else $error("link clock stopped during a command");
    chk_cmd_hold: assert property (!linkClk |=> $stable(cmdData))
        else $error("command byte changed between link ticks");
    // a zero address byte is followed by data, so the start needs two idle link cycles before it
    chk_start_code: assert property ((cmdData != 8'h00) && ($past(cmdData) == 8'h00)
        && ($past(cmdData, 3) == 8'h00)
        |-> (cmdData & 8'hbf) == 8'h80)
        else $error("transfer did not open with a start command");
    chk_ack_one_tick: assert property ($rose(rspAck) |=> rspAck ##1 !rspAck)
        else $error("acknowledge not one link cycle long");
    chk_ack_on_idle: assert property (rspAck |-> cmdData == 8'h00)
        else $error("acknowledge while a command is on the lines");
    chk_idle_gap: assert property ((cmdData == 8'h00) && ($past(cmdData) != 8'h00)
        && ($past(cmdData, 3) != 8'h00)
        |-> ##2 cmdData == 8'h00)
        else $error("no idle link cycle between transfers");
    chk_err_with_ack: assert property (rspErr |-> rspAck)
        else $error("target error outside an acknowledge");
endmodule

// ===== tb/die_link_initiator_ctrl_status_tb.sv
`timescale 1ns/1ps

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

// ==========================================
// bench top
module die_link_initiator_ctrl_status_tb;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic specialMode = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, prdata2, rd, rd2;
    logic pready, pslverr, slv, linkErrIrq, targetIrqOut;
    logic irqReq = 1'b0;
    logic errInject = 1'b0;
    logic parityInject = 1'b0;
    logic [3:0] waitStates = 4'h0;
    logic wrStrobe;
    logic [7:0] wrAddr, wrData, a, d;
    int failures = 0;
    int cmp_count = 0;
    int lim, n;
    int wrCount = 0;
    int model [256];

    always #5 core_clk = ~core_clk;

    // writes that really reach the target
    always @(posedge core_clk) begin
        if (wrStrobe === 1'b1) begin
            wrCount++;
        end
    end

    dli_link_if link ();
    dli_link_if link2 ();

    dli_initiator dli_initiator_i (.core_clk(core_clk), .srst(srst), .specialMode(specialMode),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .linkErrIrq(linkErrIrq), .targetIrqOut(targetIrqOut), .link(link));
    dli_target dli_target_i (.core_clk(core_clk), .srst(srst), .irqReq(irqReq), .waitStates(waitStates),
        .errInject(errInject), .parityInject(parityInject), .wrStrobe(wrStrobe), .wrAddr(wrAddr),
        .wrData(wrData), .link(link));
    dli_assertions dli_assertions_i (.core_clk(core_clk), .srst(srst), .linkClk(link.linkClk),
        .cmdData(link.cmdData), .rspData(link.rspData), .rspParity(link.rspParity), .rspAck(link.rspAck),
        .rspErr(link.rspErr), .targetIrqPin(link.targetIrqPin));

    // second initiator facing a responder with a broken data wire
    dli_initiator dli_initiator_fault_i (.core_clk(core_clk), .srst(srst), .specialMode(specialMode),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata2),
        .pready(), .pslverr(), .linkErrIrq(), .targetIrqOut(), .link(link2));
    assign link2.rspData = 8'h7e;
    assign link2.rspParity = 2'b00;
    assign link2.rspAck = 1'b1;
    assign link2.rspErr = 1'b0;
    assign link2.targetIrqPin = 1'b0;

    function automatic logic [7:0] par(input logic [7:0] v);
        return {6'h0, ^v[7:4], ^v[3:0]};
    endfunction

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        rd2 = prdata2;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic xfer(input logic rdn, input logic [7:0] ad, input logic [7:0] wd, input logic busy);
        apb(1'b1, 8'h10, {15'h0, rdn, ad, wd});
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd[6], busy)
        n = 0;
        while (rd[6] === 1'b1 && n < 100) begin
            apb(1'b0, 8'h0c, 32'h0);
            n++;
        end
        `CHK(rd[6], 1'b0)
    endtask

    task automatic chk_err(input logic [7:0] e);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd[7:0] & 8'hfc, e)
        `CHK(linkErrIrq, e[7])
    endtask

    task automatic done(input string s);
        $display("test %s done, checks %0d", s, cmp_count);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        $display("watchdog expired");
        finish_test;
    end

    initial begin
        void'($urandom(32'h987702be));
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        // ==========================================
        // reset values and decode
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h18, 32'h0);
        `CHK({slv, rd}, {1'b1, 32'h0})
        done("reset");
        // ==========================================
        // target interrupt mirror and gating
        irqReq <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd, 32'h80)
        `CHK(targetIrqOut, 1'b0)
        lim = 2 + $urandom_range(5);
        apb(1'b1, 8'h04, 32'h80 | lim);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h80 | lim)
        `CHK(targetIrqOut, 1'b1)
        irqReq <= 1'b0;
        repeat (3) @(posedge core_clk);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK({targetIrqOut, rd}, 33'h0)
        done("irq");
        // ==========================================
        // enable locks the wait limit
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b1, 8'h04, 32'h80 | (lim ^ 1));
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h80 | lim)
        done("lock");
        // ==========================================
        // writes and reads within the wait limit
        for (int i = 0; i < 6; i++) begin
            a = 8'($urandom);
            d = 8'($urandom);
            waitStates <= (i == 0) ? 4'(lim) : 4'($urandom_range(lim));
            model[a] = d;
            xfer(1'b0, a, d, 1'b1);
            `CHK({wrAddr, wrData}, {a, d})
            xfer(1'b1, a, 8'h00, 1'b1);
            apb(1'b0, 8'h14, 32'h0);
            `CHK(rd[7:0], 8'(model[a]))
            apb(1'b0, 8'h08, 32'h0);
            `CHK(rd[7:0], par(8'(model[a])))
        end
        `CHK(rd2[7:0] & 8'hfc, 8'he0)
        done("transfers");
        // ==========================================
        // timeout, cancel, clearing
        waitStates <= 4'(lim + 1);
        xfer(1'b0, 8'h5a, 8'h3c, 1'b1);
        chk_err(8'h90);
        xfer(1'b0, 8'h5b, 8'h00, 1'b0);
        chk_err(8'hb0);
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h0000_5a3c)
        `CHK(wrAddr, 8'h5a)
        apb(1'b1, 8'h08, 32'h0);
        chk_err(8'hb0);
        apb(1'b1, 8'h08, 32'h80);
        chk_err(8'h00);
        done("timeout");
        // ==========================================
        // target error and parity fault
        waitStates <= 4'h0;
        errInject <= 1'b1;
        xfer(1'b0, 8'h11, 8'h22, 1'b1);
        chk_err(8'h88);
        errInject <= 1'b0;
        parityInject <= 1'b1;
        apb(1'b1, 8'h08, 32'h80);
        xfer(1'b1, 8'h5a, 8'h00, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd[7:0], 8'h84 | (par(8'h3c) ^ 8'h01))
        parityInject <= 1'b0;
        apb(1'b1, 8'h08, 32'h80);
        done("target error");
        // ==========================================
        // special mode: zero wait limit
        specialMode <= 1'b1;
        apb(1'b1, 8'h04, 32'h80);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h80)
        xfer(1'b0, 8'h01, 8'h02, 1'b1);
        chk_err(8'h00);
        waitStates <= 4'h1;
        xfer(1'b0, 8'h01, 8'h03, 1'b1);
        chk_err(8'h90);
        done("special");
        `CHK(wrCount, 10)
        finish_test;
    end
endmodule
